// file: design/gpcfg_top.sv
// Behaviour
// [R1] Bit 0 set makes the pin an input, clear makes it a driven output; a selected alternate output drives the pin whatever bit 0 holds.
// [R2] Bit 1 set inverts the pin value between pad and data path in both directions.
// [R3] Bit 7 set selects open-drain drive, clear selects push-pull.
// [R4] Pin 2.0 bits 3:2 pick GPIO, kbc port bit 17, floppy drive select 1; code 3 reserved.
// [R5] Pin 2.1 bits 3:2 pick GPIO, kbc bit 16, edge interrupt input 0 or interrupt request 6.
// [R6] Pin 2.2 bits 3:2 pick GPIO, kbc bit 12, edge interrupt input 1 or floppy motor select 1.
// [R7] Pins 2.3 to 2.6 have only direction, polarity and output type bits.
// [R8] Pin 2.7 bit 2 routes the system management interrupt output onto the pin.
// [R9] Pin 3.0 bit 2 makes the pin the SMBus clock line.
// [R10] Every register loads 0x01 on standby power-on reset.
// [R11] Reserved bits read zero and ignore writes; reserved codes behave as basic GPIO.
`timescale 1ns/100ps
`default_nettype none
module gpcfg_top
#(
  // Width of the word index on the register bus
  parameter int unsigned ADR_W = 8
)
(
  // Clock and standby reset
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  // Wishbone slave
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [ADR_W-1:0]                wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  output logic                                 wb_err_o,
  // Pads: index 0..7 are pins 2.0..2.7, index 8 is pin 3.0
  input  wire logic [gpcfg_pkg::NUM_PINS-1:0]  pad_in_i,
  output logic      [gpcfg_pkg::NUM_PINS-1:0]  pad_out_o,
  output logic      [gpcfg_pkg::NUM_PINS-1:0]  pad_oe_o,
  // Basic GPIO data path
  input  wire logic [gpcfg_pkg::NUM_PINS-1:0]  gpio_out_i,
  output logic      [gpcfg_pkg::NUM_PINS-1:0]  gpio_in_o,
  // Alternate function units
  input  wire logic                            kbc_port_bit_seventeen_i,
  input  wire logic                            kbc_port_bit_sixteen_i,
  input  wire logic                            kbc_port_bit_twelve_i,
  input  wire logic                            floppy_drive_select_1_i,
  input  wire logic                            floppy_motor_select_1_i,
  input  wire logic                            system_mgmt_interrupt_out_i,
  input  wire logic                            smbus_clk_out_i,
  output logic                                 kbc_port_bit_seventeen_o,
  output logic                                 kbc_port_bit_sixteen_o,
  output logic                                 kbc_port_bit_twelve_o,
  output logic                                 edge_irq_in_0_o,
  output logic                                 edge_irq_in_1_o,
  output logic                                 irq6_in_o,
  output logic                                 smbus_clk_in_o
);

  localparam int unsigned N = gpcfg_pkg::NUM_PINS;

  // Offsets reach 0x33, which needs six index bits
  if (ADR_W < 6)
  begin : g_adr_check
    $error("ADR_W too narrow for the register offsets");
  end

  // Alternate routing is wired to fixed pin indices
  if (N != 9)
  begin : g_pin_check
    $error("NUM_PINS must be 9 for the fixed alternate routing");
  end

  logic [7:0]       cfg_r [N];
  logic [N-1:0]     hit;
  logic             any_hit;
  logic             ack_r;
  logic             err_r;
  logic [31:0]      dat_r;
  logic [7:0]       rd_mux;
  logic [N-1:0]     inv;
  logic [N-1:0]     pin_val;
  logic [N-1:0]     alt_en;
  logic [N-1:0]     alt_drv;
  logic [N-1:0]     core_out;
  logic [N-1:0]     alt_sel;
  logic [N-1:0]     pad_out_c;
  logic [N-1:0]     pad_oe_c;
  logic [N-1:0]     gpio_in_c;
  logic             wr_en;
  logic             rd_en;
  gpcfg_pkg::gpcfg_pad_s pad [N];

  function automatic logic [7:0] wmask(input int unsigned idx);
    if (idx <= 2)
      return gpcfg_pkg::MASK_SEL2;
    else if (idx == 7 || idx == 8)
      return gpcfg_pkg::MASK_SEL1;
    else
      return gpcfg_pkg::MASK_PLAIN;
  endfunction

  wire logic req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;

  // Accepted write and read
  assign wr_en = req && wb_we_i && wb_sel_i[0];
  assign rd_en = req && !wb_we_i && any_hit;

  // Register file and pin datapath per pin
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      localparam logic [7:0] MASK = wmask(g);
      assign hit[g] = (wb_adr_i == ADR_W'(gpcfg_pkg::OFS_FIRST + 8'(g)));

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          cfg_r[g] <= gpcfg_pkg::CFG_RESET;  // [R10]
        else if (wr_en && hit[g])
          cfg_r[g] <= wb_dat_i[7:0] & MASK;  // [R11] [R7]
      end

      assign inv[g]     = cfg_r[g][gpcfg_pkg::BIT_INVERT];
      assign pin_val[g] = pad_in_i[g] ^ inv[g];  // [R2]

      // Pad drive from core value, direction and driver style
      always_comb
      begin
        pad[g].out = 1'b0;
        pad[g].oe  = 1'b0;
        if (alt_en[g])
        begin
          pad[g].out = alt_drv[g] ^ inv[g];
          pad[g].oe  = 1'b1;
        end
        else if (!cfg_r[g][gpcfg_pkg::BIT_DIR_IN])  // [R1]
        begin
          pad[g].out = core_out[g] ^ inv[g];  // [R2]
          pad[g].oe  = 1'b1;
        end
        if (cfg_r[g][gpcfg_pkg::BIT_OPEN_DRAIN] && pad[g].out)  // [R3]
          pad[g].oe = 1'b0;
        if (!pad[g].oe)
          pad[g].out = 1'b0;
      end

      assign pad_out_c[g] = pad[g].out;
      assign pad_oe_c[g]  = pad[g].oe;
      assign gpio_in_c[g] = alt_sel[g] ? 1'b0 : pin_val[g];
    end
  endgenerate

  assign core_out = gpio_out_i;

  // Pad and GPIO data outputs from flip-flops; pads released in reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_out_o <= '0;
      pad_oe_o  <= '0;
      gpio_in_o <= '0;
    end
    else
    begin
      pad_out_o <= pad_out_c;
      pad_oe_o  <= pad_oe_c;
      gpio_in_o <= gpio_in_c;
    end
  end

  // Alternate function routing
  wire logic [1:0] sel0 = cfg_r[0][gpcfg_pkg::BIT_ALT_HI:gpcfg_pkg::BIT_ALT_LO];
  wire logic [1:0] sel1 = cfg_r[1][gpcfg_pkg::BIT_ALT_HI:gpcfg_pkg::BIT_ALT_LO];
  wire logic [1:0] sel2 = cfg_r[2][gpcfg_pkg::BIT_ALT_HI:gpcfg_pkg::BIT_ALT_LO];
  wire logic       sel7 = cfg_r[7][gpcfg_pkg::BIT_ALT_LO];
  wire logic       sel8 = cfg_r[8][gpcfg_pkg::BIT_ALT_LO];

  always_comb
  begin
    alt_en  = '0;
    alt_drv = '0;
    // Keyboard port bits are bidirectional: drive while enabled, read the pad
    case (sel0)  // [R4] [R11]
      gpcfg_pkg::GPCFG_ALT_F1:
      begin
        alt_en[0]  = 1'b1;
        alt_drv[0] = kbc_port_bit_seventeen_i;
      end
      gpcfg_pkg::GPCFG_ALT_F2:
      begin
        alt_en[0]  = 1'b1;
        alt_drv[0] = floppy_drive_select_1_i;
      end
      default:
        alt_en[0] = 1'b0;
    endcase
    case (sel1)  // [R5]
      gpcfg_pkg::GPCFG_ALT_F1:
      begin
        alt_en[1]  = 1'b1;
        alt_drv[1] = kbc_port_bit_sixteen_i;
      end
      default:
        alt_en[1] = 1'b0;
    endcase
    case (sel2)  // [R6]
      gpcfg_pkg::GPCFG_ALT_F1:
      begin
        alt_en[2]  = 1'b1;
        alt_drv[2] = kbc_port_bit_twelve_i;
      end
      gpcfg_pkg::GPCFG_ALT_F3:
      begin
        alt_en[2]  = 1'b1;
        alt_drv[2] = floppy_motor_select_1_i;
      end
      default:
        alt_en[2] = 1'b0;
    endcase
    if (sel7)  // [R8]
    begin
      alt_en[7]  = 1'b1;
      alt_drv[7] = system_mgmt_interrupt_out_i;
    end
    if (sel8)  // [R9]
    begin
      alt_en[8]  = 1'b1;
      alt_drv[8] = smbus_clk_out_i;
    end
  end

  // Input-only alternates take the pin off the GPIO data path as well
  always_comb
  begin
    alt_sel    = alt_en;
    alt_sel[1] = (sel1 != gpcfg_pkg::GPCFG_ALT_GPIO);  // [R5]
    alt_sel[2] = (sel2 != gpcfg_pkg::GPCFG_ALT_GPIO);  // [R6]
  end

  // Inputs to alternate units from flip-flops, idle level when not selected
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      kbc_port_bit_seventeen_o <= 1'b1;
      kbc_port_bit_sixteen_o   <= 1'b1;
      kbc_port_bit_twelve_o    <= 1'b1;
      edge_irq_in_0_o          <= 1'b0;
      edge_irq_in_1_o          <= 1'b0;
      irq6_in_o                <= 1'b0;
      smbus_clk_in_o           <= 1'b1;
    end
    else
    begin
      kbc_port_bit_seventeen_o <= (sel0 == gpcfg_pkg::GPCFG_ALT_F1) ? pin_val[0] : 1'b1;  // [R4]
      kbc_port_bit_sixteen_o   <= (sel1 == gpcfg_pkg::GPCFG_ALT_F1) ? pin_val[1] : 1'b1;  // [R5]
      kbc_port_bit_twelve_o    <= (sel2 == gpcfg_pkg::GPCFG_ALT_F1) ? pin_val[2] : 1'b1;  // [R6]
      edge_irq_in_0_o          <= (sel1 == gpcfg_pkg::GPCFG_ALT_F2) ? pin_val[1] : 1'b0;  // [R5]
      edge_irq_in_1_o          <= (sel2 == gpcfg_pkg::GPCFG_ALT_F2) ? pin_val[2] : 1'b0;  // [R6]
      irq6_in_o                <= (sel1 == gpcfg_pkg::GPCFG_ALT_F3) ? pin_val[1] : 1'b0;  // [R5]
      smbus_clk_in_o           <= sel8 ? pin_val[8] : 1'b1;  // [R9]
    end
  end

  // Wishbone slave: one-cycle registered answer
  assign any_hit = |hit;

  // Read-back multiplexer, zero for an unmapped index
  always_comb
  begin
    rd_mux = 8'h00;
    for (int i = 0; i < N; i++)
      if (hit[i])
        rd_mux = cfg_r[i];
  end

  // A held request is not taken again while ack or err stands
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      ack_r <= req && any_hit;
      err_r <= req && !any_hit;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= 32'h0000_0000;
    else if (rd_en)
      dat_r <= {24'h00_0000, rd_mux};
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = dat_r;

endmodule // gpcfg_top
`default_nettype wire

// file: design/gpcfg_pkg.sv
package gpcfg_pkg;

  localparam int unsigned NUM_PINS = 9;

  // Register offsets (byte addresses are four times these)
  localparam logic [7:0] OFS_PIN_2_0 = 8'h2B;
  localparam logic [7:0] OFS_PIN_2_1 = 8'h2C;
  localparam logic [7:0] OFS_PIN_2_2 = 8'h2D;
  localparam logic [7:0] OFS_PIN_2_3 = 8'h2E;
  localparam logic [7:0] OFS_PIN_2_4 = 8'h2F;
  localparam logic [7:0] OFS_PIN_2_5 = 8'h30;
  localparam logic [7:0] OFS_PIN_2_6 = 8'h31;
  localparam logic [7:0] OFS_PIN_2_7 = 8'h32;
  localparam logic [7:0] OFS_PIN_3_0 = 8'h33;
  localparam logic [7:0] OFS_FIRST   = OFS_PIN_2_0;

  // Field positions
  localparam int unsigned BIT_DIR_IN = 0;
  localparam int unsigned BIT_INVERT = 1;
  localparam int unsigned BIT_ALT_LO = 2;
  localparam int unsigned BIT_ALT_HI = 3;
  localparam int unsigned BIT_OPEN_DRAIN = 7;

  localparam logic [7:0] CFG_RESET = 8'h01;
  // Writable masks: two-bit selector pins, one-bit selector pins, plain pins
  localparam logic [7:0] MASK_SEL2 = 8'h8F;
  localparam logic [7:0] MASK_SEL1 = 8'h87;
  localparam logic [7:0] MASK_PLAIN = 8'h83;

  typedef enum logic [1:0] {
    GPCFG_ALT_GPIO = 2'h0,
    GPCFG_ALT_F1   = 2'h1,
    GPCFG_ALT_F2   = 2'h2,
    GPCFG_ALT_F3   = 2'h3
  } gpcfg_alt_e;

  // Per-pin pad signals
  typedef struct packed {
    logic out;
    logic oe;
  } gpcfg_pad_s;

endpackage

// file: tb/gpcfg_chk.sv
`timescale 1ns/100ps
`default_nettype none
module gpcfg_chk
(
  // Clock and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // Pads and routed inputs
  input wire logic [8:0]  pad_out_o,
  input wire logic [8:0]  pad_oe_o,
  input wire logic [8:0]  gpio_in_o,
  input wire logic        kbc_port_bit_seventeen_o,
  input wire logic        edge_irq_in_0_o,
  input wire logic        edge_irq_in_1_o,
  input wire logic        irq6_in_o,
  input wire logic        smbus_clk_in_o
);
  logic take;
  logic hit;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit  = wb_adr_i >= 8'h2B && wb_adr_i <= 8'h33;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rst_idle: assert property ($past(rst_i) |-> pad_oe_o == 9'h000 && wb_dat_o == 32'h0)
    else $error("pads or data not idle after reset");
  a_ack_mapped: assert property (take && hit |=> wb_ack_o && !wb_err_o ##1 !wb_ack_o)
    else $error("mapped access not acked for one cycle");
  a_err_unmapped: assert property (take && !hit |=> wb_err_o && !wb_ack_o ##1 !wb_err_o)
    else $error("unmapped access not refused");
  a_rsvd_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[6:4] == 3'h0)
    else $error("reserved read bits not zero");
  a_od_low_only: assert property ((pad_out_o & ~pad_oe_o) == 9'h000)
    else $error("pad output high while released");
  a_kbc_excl: assert property (!kbc_port_bit_seventeen_o |-> !gpio_in_o[0])
    else $error("pin 2.0 routed to two paths");
  a_irq0_excl: assert property (edge_irq_in_0_o |-> !gpio_in_o[1] && !irq6_in_o)
    else $error("pin 2.1 routed to two paths");
  a_irq1_excl: assert property (edge_irq_in_1_o |-> !gpio_in_o[2])
    else $error("pin 2.2 routed to two paths");
  a_smb_excl: assert property (!smbus_clk_in_o |-> !gpio_in_o[8])
    else $error("pin 3.0 routed to two paths");
endmodule // gpcfg_chk
`default_nettype wire

// file: tb/gpcfg_pads.sv
`timescale 1ns/100ps
`default_nettype none
module gpcfg_pads
(
  // Block pad drivers and board levels
  input  wire logic [8:0] pad_out_i,
  input  wire logic [8:0] pad_oe_i,
  input  wire logic [8:0] ext_i,
  output logic      [8:0] pad_o
);
  // Released pins follow the board level
  assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule // gpcfg_pads
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, e;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [8:0]  po, oe, pin, gout, gin, ext;
  logic [6:0]  alt, ai;
  int          bad_count, compares, ncyc;
  gpcfg_top i_gpcfg_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .pad_in_i(pin), .pad_out_o(po), .pad_oe_o(oe),
    .gpio_out_i(gout), .gpio_in_o(gin), .kbc_port_bit_seventeen_i(alt[0]),
    .kbc_port_bit_sixteen_i(alt[1]), .kbc_port_bit_twelve_i(alt[2]),
    .floppy_drive_select_1_i(alt[3]), .floppy_motor_select_1_i(alt[4]),
    .system_mgmt_interrupt_out_i(alt[5]), .smbus_clk_out_i(alt[6]),
    .kbc_port_bit_seventeen_o(ai[0]), .kbc_port_bit_sixteen_o(ai[1]),
    .kbc_port_bit_twelve_o(ai[2]), .edge_irq_in_0_o(ai[3]), .edge_irq_in_1_o(ai[4]),
    .irq6_in_o(ai[5]), .smbus_clk_in_o(ai[6]));
  gpcfg_pads i_gpcfg_pads (.pad_out_i(po), .pad_oe_i(oe), .ext_i(ext), .pad_o(pin));
  task end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [32:0] g, input logic [32:0] x);
    compares++;
    if (g !== x)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask
  task wb(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [7:0] d);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w;
    wb_adr_i <= a; wb_sel_i <= s; wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    wb(a, 1'b0, 4'hF, 8'h00);
    chk({e, q}, {9'h000, 16'h0, x});
  endtask
  task cfg(input int i, input logic [7:0] v);
    wb(8'h2B + i[7:0], 1'b1, 4'h1, v);
    // Routed inputs settle two edges after the write
    @(posedge clk_i);
  endtask
  initial
  begin
    clk_i = 0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (++ncyc == 2000)
    begin
      bad_count++;
      end_of_test;
    end
  initial
  begin
    rst_i = 1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_adr_i = 0; wb_sel_i = 0;
    wb_dat_i = 0; gout = 0; ext = 9'h1FF; alt = 7'h78; bad_count = 0; compares = 0; ncyc = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (int i = 0; i < 9; i++) rd(8'h2B + i[7:0], 8'h01);
    wb(8'h2A, 1'b0, 4'hF, 8'h00); chk(e, 1);
    wb(8'h34, 1'b1, 4'h1, 8'hFF); chk(e, 1);
    $display("test reset done");
    for (int i = 0; i < 9; i++)
    begin
      cfg(i, 8'hFF);
      rd(8'h2B + i[7:0], (i < 3) ? 8'h8F : (i > 6) ? 8'h87 : 8'h83);
    end
    wb(8'h2E, 1'b1, 4'hE, 8'h00); rd(8'h2E, 8'h83);
    $display("test masks done");
    gout <= 9'h008; cfg(3, 8'h00); chk({oe[3], po[3]}, 2'b11);
    cfg(3, 8'h02); chk({oe[3], po[3]}, 2'b10);
    cfg(3, 8'h82); chk({oe[3], po[3]}, 2'b10);
    gout <= 9'h000; repeat (2) @(posedge clk_i); chk(oe[3], 0);
    ext <= 9'h1F7; cfg(3, 8'h03); chk({oe[3], gin[3]}, 2'b01);
    $display("test pin path done");
    ext <= 9'h1FF; cfg(0, 8'h05); chk(ai[0], 0);
    cfg(0, 8'h09); chk({oe[0], po[0]}, 2'b11);
    cfg(0, 8'h0D); chk({oe[0], gin[0]}, 2'b01);
    cfg(1, 8'h05); chk(ai[1], 0);
    cfg(1, 8'h09); chk({gin[1], ai[5:3]}, 4'b0001);
    cfg(1, 8'h0D); chk(ai[5:3], 3'b100);
    cfg(2, 8'h05); chk(ai[2], 0);
    cfg(2, 8'h09); chk(ai[4], 1);
    cfg(2, 8'h0D); chk({oe[2], po[2]}, 2'b11);
    cfg(7, 8'h05); chk({oe[7], po[7]}, 2'b11);
    cfg(7, 8'h07); chk(po[7], 0);
    ext <= 9'h0FF; cfg(8, 8'h85); chk({oe[8], ai[6]}, 2'b00);
    rst_i <= 1; @(posedge clk_i); rst_i <= 0; @(posedge clk_i);
    rd(8'h33, 8'h01);
    $display("test alternates done");
    end_of_test;
  end
endmodule // tb_top
bind gpcfg_top gpcfg_chk i_gpcfg_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .wb_err_o, .pad_out_o, .pad_oe_o, .gpio_in_o,
  .kbc_port_bit_seventeen_o, .edge_irq_in_0_o, .edge_irq_in_1_o, .irq6_in_o, .smbus_clk_in_o);
`default_nettype wire
